// >>> rtl/acr_params.svh
// Offsets, field positions, reset values and timing counts of the control group
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_OFF_BOOT      8'h22
`define ACR_OFF_SSM       8'h28
`define ACR_OFF_PORT      8'h2A
`define ACR_OFF_BOOST     8'h2B
`define ACR_OFF_CFG       8'h2C
`define ACR_OFF_TO1       8'h2D
`define ACR_OFF_TO2       8'h2E
`define ACR_OFF_RECOV     8'h32
`define ACR_RST_BOOT      8'h01
`define ACR_RST_SSM       8'h00
`define ACR_RST_PORT      8'h00
`define ACR_RST_BOOST     8'h03
`define ACR_RST_CFG       8'h00
`define ACR_RST_TO1       8'h17
`define ACR_RST_TO2       8'h00
`define ACR_RST_RECOV     8'h00
`define ACR_BIT_SPREAD_SPECTRUM_EN    0
`define ACR_BIT_MUTE_SS   0
`define ACR_BIT_E1_SM     5
`define ACR_BIT_E1_IC     4
`define ACR_BIT_E1_EN     1
`define ACR_BIT_E2_EN     0
`define ACR_BIT_E1_RM     0
`define ACR_BIT_E2_RM     1
`define ACR_CLK_HZ        10000000
`define ACR_TO_US_0       2730
`define ACR_TO_US_1       22000
`define ACR_TO_US_2       44000
`define ACR_TO_US_3       87000
`define ACR_TO_US_4       174000
`define ACR_TO_US_5       350000
`define ACR_TO_US_6       700000
`define ACR_TO_US_7       1400000
`define ACR_US_CYC(us)    ((us) * (`ACR_CLK_HZ / 1000000))
`endif

// >>> rtl/acr_pkg.sv
// Types shared by the amplifier control register group
`default_nettype none
package acr_pkg;
   typedef enum logic [3:0] {
      ACR_BOOT_RSVD0  = 4'h0,
      ACR_BOOT_PLAY   = 4'h1,
      ACR_BOOT_PLAYIV = 4'h2,
      ACR_BOOT_PROT   = 4'h3,
      ACR_BOOT_PROTVC = 4'h4
   } acr_boot_e;
   typedef enum logic [1:0] {
      ACR_CH_LEFT  = 2'h0,
      ACR_CH_RIGHT = 2'h1,
      ACR_CH_AVG   = 2'h2,
      ACR_CH_MONO  = 2'h3
   } acr_chan_e;
   typedef enum logic [1:0] {
      ACR_DET_IDLE  = 2'b00,
      ACR_DET_WATCH = 2'b01,
      ACR_DET_FAULT = 2'b10
   } acr_det_e;
   typedef logic [23:0] acr_count_t;
endpackage : acr_pkg
`default_nettype wire

// >>> rtl/acr_clk_detector.sv
// One clock-absence detector with timeout and optional auto recovery
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_clk_detector
   import acr_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        enable,
   input  wire logic        clk_edge,
   input  wire logic [2:0]  timeout_sel,
   input  wire logic        recovery_off,
   output logic             fault
);
   // ************************************************
   // Timeout lookup
   // ************************************************
   function automatic acr_count_t limit_of(input logic [2:0] sel);
      unique case (sel)
         3'd0: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_0));
         3'd1: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_1));
         3'd2: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_2));
         3'd3: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_3));
         3'd4: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_4));
         3'd5: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_5));
         3'd6: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_6));
         3'd7: limit_of = 24'(`ACR_US_CYC(`ACR_TO_US_7));
      endcase
   endfunction : limit_of

   acr_det_e   state;
   acr_det_e   next_state;
   acr_count_t count;
   acr_count_t next_count;

   // Absence counter; any edge restarts it
   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         ACR_DET_IDLE: begin
            next_count = '0;
            if (enable) next_state = ACR_DET_WATCH;
         end
         ACR_DET_WATCH: begin
            if (!enable) begin
               next_state = ACR_DET_IDLE;
            end else if (clk_edge) begin
               next_count = '0;
            end else if (count + 24'd1 >= limit_of(timeout_sel)) begin
               next_state = ACR_DET_FAULT;
               next_count = '0;
            end else begin
               next_count = count + 24'd1;
            end
         end
         ACR_DET_FAULT: begin
            // Latched fault holds until clock returns or enable drops; with recovery off only enable dropping clears it
            if (!enable) next_state = ACR_DET_IDLE;
            else if (clk_edge && !recovery_off)
               next_state = ACR_DET_WATCH;
         end
         default: next_state = ACR_DET_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= ACR_DET_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign fault = (state == ACR_DET_FAULT);
endmodule : acr_clk_detector
`default_nettype wire

// >>> rtl/acr_regs.sv
// Control register group: boot, spread spectrum, ports, boost, clock errors
// Behaviour
// - Boot mode field selects processor boot mode
// - Spread-spectrum bit enables modulator spreading
// - Port two channel select field
// - Port one channel select field
// - Mute soft-step bit low ramps gain
// - Boost limit code selects 1.5 to 3.0 A
// - Detector one mute method bit
// - Detector one clock from port one or two
// - Detector two clock: DAC, ADC or PLL
// - Each detector runs only while enabled
// - Detector one timeout shuts down, flags fault
// - Detector two timeout shuts down, flags fault
// - Detector one recovery-disable bit blocks recovery
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_regs
   import acr_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        port1_clk_edge,
   input  wire logic        port2_clk_edge,
   input  wire logic        dac_clk_edge,
   input  wire logic        adc_clk_edge,
   input  wire logic        pll_clk_edge,
   output logic      [3:0]  boot_mode,
   output logic             spread_spectrum_en,
   output logic      [1:0]  port1_channel_sel,
   output logic      [1:0]  port2_channel_sel,
   output logic             mute_soft_step_off,
   output logic      [1:0]  boost_current_limit,
   output logic             err1_mute_method,
   output logic             clock_fault_mute,
   output logic             device_shutdown,
   output logic             power_fault_flag
);
   // ************************************************
   // Register storage
   // ************************************************
   logic [7:0] boot_ctl, ssm_ctl, port_ctl, boost_ctl;
   logic [7:0] cfg_ctl, to1_ctl, to2_ctl, recov_ctl;
   logic [7:0] next_boot_ctl, next_ssm_ctl, next_port_ctl, next_boost_ctl;
   logic [7:0] next_cfg_ctl, next_to1_ctl, next_to2_ctl, next_recov_ctl;
   logic [7:0] next_rdata;
   logic       fault1, fault2;
   logic       err1_edge, err2_edge;
   logic       next_pfault;

   // Write decode; all bits stored so reserved fields read back
   always_comb begin
      next_boot_ctl  = boot_ctl;
      next_ssm_ctl   = ssm_ctl;
      next_port_ctl  = port_ctl;
      next_boost_ctl = boost_ctl;
      next_cfg_ctl   = cfg_ctl;
      next_to1_ctl   = to1_ctl;
      next_to2_ctl   = to2_ctl;
      next_recov_ctl = recov_ctl;
      if (reg_wr) begin
         unique case (reg_addr)
            `ACR_OFF_BOOT:  next_boot_ctl  = reg_wdata;
            `ACR_OFF_SSM:   next_ssm_ctl   = reg_wdata;
            `ACR_OFF_PORT:  next_port_ctl  = reg_wdata;
            `ACR_OFF_BOOST: next_boost_ctl = reg_wdata;
            `ACR_OFF_CFG:   next_cfg_ctl   = reg_wdata;
            `ACR_OFF_TO1:   next_to1_ctl   = reg_wdata;
            `ACR_OFF_TO2:   next_to2_ctl   = reg_wdata;
            `ACR_OFF_RECOV: next_recov_ctl = reg_wdata;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            `ACR_OFF_BOOT:  next_rdata = boot_ctl;
            `ACR_OFF_SSM:   next_rdata = ssm_ctl;
            `ACR_OFF_PORT:  next_rdata = port_ctl;
            `ACR_OFF_BOOST: next_rdata = boost_ctl;
            `ACR_OFF_CFG:   next_rdata = cfg_ctl;
            `ACR_OFF_TO1:   next_rdata = to1_ctl;
            `ACR_OFF_TO2:   next_rdata = to2_ctl;
            `ACR_OFF_RECOV: next_rdata = recov_ctl;
            default:        next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         boot_ctl  <= `ACR_RST_BOOT;
         ssm_ctl   <= `ACR_RST_SSM;
         port_ctl  <= `ACR_RST_PORT;
         boost_ctl <= `ACR_RST_BOOST;
         cfg_ctl   <= `ACR_RST_CFG;
         to1_ctl   <= `ACR_RST_TO1;
         to2_ctl   <= `ACR_RST_TO2;
         recov_ctl <= `ACR_RST_RECOV;
         reg_rdata <= 8'h00;
      end else begin
         boot_ctl  <= next_boot_ctl;
         ssm_ctl   <= next_ssm_ctl;
         port_ctl  <= next_port_ctl;
         boost_ctl <= next_boost_ctl;
         cfg_ctl   <= next_cfg_ctl;
         to1_ctl   <= next_to1_ctl;
         to2_ctl   <= next_to2_ctl;
         recov_ctl <= next_recov_ctl;
         reg_rdata <= next_rdata;
      end
   end

   // ************************************************
   // Field outputs
   // ************************************************
   // Spread spectrum relies on host keeping the ramp clock internal
   assign spread_spectrum_en  = ssm_ctl[`ACR_BIT_SPREAD_SPECTRUM_EN];
   assign boot_mode           = boot_ctl[3:0];
   assign port2_channel_sel   = port_ctl[4:3];
   assign port1_channel_sel   = port_ctl[2:1];
   assign mute_soft_step_off  = port_ctl[`ACR_BIT_MUTE_SS];
   assign boost_current_limit = boost_ctl[1:0];
   assign err1_mute_method    = cfg_ctl[`ACR_BIT_E1_SM];

   // ************************************************
   // Clock error detectors
   // ************************************************
   // Detector one clock source
   assign err1_edge = cfg_ctl[`ACR_BIT_E1_IC] ? port2_clk_edge
                                              : port1_clk_edge;
   // Detector two source; reserved code sees no edges
   always_comb begin
      unique case (cfg_ctl[3:2])
         2'd0:    err2_edge = dac_clk_edge;
         2'd1:    err2_edge = adc_clk_edge;
         2'd2:    err2_edge = pll_clk_edge;
         default: err2_edge = 1'b0;
      endcase
   end

   acr_clk_detector u_det1 (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .enable       (cfg_ctl[`ACR_BIT_E1_EN]),
      .clk_edge     (err1_edge),
      .timeout_sel  (to1_ctl[2:0]),
      .recovery_off (recov_ctl[`ACR_BIT_E1_RM]),
      .fault        (fault1)
   );
   acr_clk_detector u_det2 (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .enable       (cfg_ctl[`ACR_BIT_E2_EN]),
      .clk_edge     (err2_edge),
      .timeout_sel  (to2_ctl[2:0]),
      .recovery_off (recov_ctl[`ACR_BIT_E2_RM]),
      .fault        (fault2)
   );

   // Fault flag registered so it is glitch free
   assign next_pfault = fault1 | fault2;
   always_ff @(posedge mclk) begin
      if (!rst_n) power_fault_flag <= 1'b0;
      else        power_fault_flag <= next_pfault;
   end
   assign device_shutdown  = power_fault_flag;
   assign clock_fault_mute = fault1;

   // ************************************************
   // Checks
   // ************************************************
   chk_boot_reset: assert property (@(posedge mclk)
      $rose(rst_n) |-> boot_mode == 4'h1)
      else $error("boot mode not 1 after reset");
   chk_ssm_write: assert property (@(posedge mclk)
      disable iff (!rst_n)
      reg_wr && reg_addr == `ACR_OFF_SSM
      |=> spread_spectrum_en == $past(reg_wdata[0]))
      else $error("spread enable not written");
   chk_port_sel: assert property (@(posedge mclk)
      disable iff (!rst_n)
      reg_wr && reg_addr == `ACR_OFF_PORT |=>
      port2_channel_sel == $past(reg_wdata[4:3]) &&
      port1_channel_sel == $past(reg_wdata[2:1]))
      else $error("channel select not written");
   chk_mute_step: assert property (@(posedge mclk)
      disable iff (!rst_n)
      reg_wr && reg_addr == `ACR_OFF_PORT
      |=> mute_soft_step_off == $past(reg_wdata[0]))
      else $error("soft step bit not written");
   chk_boost_reset: assert property (@(posedge mclk)
      $rose(rst_n) |-> boost_current_limit == 2'd3)
      else $error("boost limit not 3 after reset");
   chk_mute_method: assert property (@(posedge mclk)
      disable iff (!rst_n)
      reg_wr && reg_addr == `ACR_OFF_CFG
      |=> err1_mute_method == $past(reg_wdata[`ACR_BIT_E1_SM]))
      else $error("mute method bit not written");
   chk_det_off: assert property (@(posedge mclk)
      disable iff (!rst_n)
      !cfg_ctl[1] && !cfg_ctl[0] ##2 !cfg_ctl[1] && !cfg_ctl[0]
      |-> !power_fault_flag)
      else $error("fault with detectors disabled");
   chk_fault_flag: assert property (@(posedge mclk)
      disable iff (!rst_n)
      fault1 || fault2 |=> power_fault_flag)
      else $error("fault flag not raised");
   // Recovery off: a returning clock must not clear detector one
   chk_mute_link: assert property (@(posedge mclk)
      disable iff (!rst_n)
      clock_fault_mute && cfg_ctl[`ACR_BIT_E1_EN]
      && recov_ctl[`ACR_BIT_E1_RM] |=> clock_fault_mute)
      else $error("detector one left fault with recovery off");
endmodule : acr_regs
`default_nettype wire

// >>> sim/acr_host.sv
// Host model that drives the control port of the register group
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the register control port
// ****************************************
module acr_host (
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // Idle port at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write cycle; released lines show inverted values, not stale ones
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge mclk);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : write_reg

   // One read cycle; registered data is settled just after the taking edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge mclk);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask : read_reg

   // Read-modify-write keeps reserved fields at their current values
   task automatic rmw(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] v);
      logic [7:0] d;
      read_reg(a, d);
      write_reg(a, (d & ~m) | (v & m));
   endtask : rmw

   // Spreading is switched by a read-modify-write of bit 0 at offset 28h
   task automatic set_spread(input logic on);
      rmw(8'h28, 8'h01, {7'h00, on});
   endtask : set_spread
endmodule : acr_host
`default_nettype wire

// >>> sim/acr_regs_test.sv
// Self-checking bench for the amplifier control register group
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_regs_test;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [4:0] edg = 5'h00;
   wire        reg_wr, reg_rd;
   wire  [7:0] reg_addr, reg_wdata;
   logic [7:0] reg_rdata, rd;
   logic [3:0] boot_mode;
   logic [1:0] p1_sel, p2_sel, ilim;
   logic       ssm, mss, mmeth, cmute, shdn, power_fault_flag;
   int         mismatches = 0;
   int         n_compared = 0;
   logic [7:0] offs [8] = '{`ACR_OFF_BOOT, `ACR_OFF_SSM, `ACR_OFF_PORT,
      `ACR_OFF_BOOST, `ACR_OFF_CFG, `ACR_OFF_TO1, `ACR_OFF_TO2,
      `ACR_OFF_RECOV};
   logic [7:0] rsts [8] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h17,
      8'h00, 8'h00};

   // 10 MHz clock
   always #50 mclk = ~mclk;

   acr_host u_acr_host (.mclk(mclk), .reg_rdata(reg_rdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));

   acr_regs u_acr_regs (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .port1_clk_edge(edg[0]),
      .port2_clk_edge(edg[1]), .dac_clk_edge(edg[2]),
      .adc_clk_edge(edg[3]), .pll_clk_edge(edg[4]),
      .boot_mode(boot_mode), .spread_spectrum_en(ssm),
      .port1_channel_sel(p1_sel), .port2_channel_sel(p2_sel),
      .mute_soft_step_off(mss), .boost_current_limit(ilim),
      .err1_mute_method(mmeth), .clock_fault_mute(cmute),
      .device_shutdown(shdn), .power_fault_flag(power_fault_flag));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic print_verdict();
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
      u_acr_host.read_reg(a, rd);
      check(rd, exp);
   endtask : check_reg

   // One-cycle pulse on the chosen clock-edge inputs
   task automatic pulse(input logic [4:0] m);
      @(posedge mclk);
      #1;
      edg = m;
      @(posedge mclk);
      #1;
      edg = 5'h00;
   endtask : pulse

   // Long absence window, only the given (unwatched) edges keep toggling
   task automatic idle(input int n, input logic [4:0] m);
      repeat (n) begin
         pulse(m);
         repeat (98) @(posedge mclk);
      end
      #2;
   endtask : idle

   // Bounded wait on the fault flag; an expired wait ends the run
   task automatic wait_fault(input int n, input logic lvl);
      int i;
      i = 0;
      n_compared++;
      while (power_fault_flag !== lvl) begin
         @(posedge mclk);
         #2;
         i++;
         if (i > n) begin
            mismatches++;
            $display("[FAIL] %0t fault flag wait expired", $time);
            print_verdict();
         end
      end
   endtask : wait_fault

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) check_reg(offs[i], rsts[i]);
      check({4'h0, boot_mode}, 8'h01);
      check({6'h00, ilim}, 8'h03);
      check({7'h00, shdn}, 8'h00);
      // Unmapped place keeps nothing
      u_acr_host.write_reg(8'h30, 8'hFF);
      check_reg(8'h30, 8'h00);
      for (int m = 1; m < 5; m++) begin
         u_acr_host.rmw(8'h22, 8'h0F, 8'(m));
         check({4'h0, boot_mode}, 8'(m));
      end
      u_acr_host.set_spread(1'b1);
      check({7'h00, ssm}, 8'h01);
      u_acr_host.set_spread(1'b0);
      check({7'h00, ssm}, 8'h00);
      for (int c = 0; c < 4; c++) begin
         u_acr_host.write_reg(8'h2A, 8'((c << 3) | ((3 - c) << 1) | (c & 1)));
         check({6'h00, p2_sel}, 8'(c));
         check({6'h00, p1_sel}, 8'(3 - c));
         check({7'h00, mss}, 8'(c & 1));
         u_acr_host.write_reg(8'h2B, 8'(c));
         check({6'h00, ilim}, 8'(c));
      end
      u_acr_host.write_reg(8'h2C, 8'h20);
      check({7'h00, mmeth}, 8'h01);
      u_acr_host.write_reg(8'h2C, 8'h00);
      check({7'h00, mmeth}, 8'h00);
      // Detector one on port two, recovery blocked, shortest absence
      u_acr_host.write_reg(8'h32, 8'h01);
      u_acr_host.rmw(8'h2D, 8'h07, 8'h00);
      check_reg(8'h2D, 8'h10);
      u_acr_host.write_reg(8'h2C, 8'h12);
      idle(270, 5'b00001);
      check({7'h00, power_fault_flag}, 8'h00);
      wait_fault(400, 1'b1);
      check({6'h00, cmute, shdn}, 8'h03);
      pulse(5'b00010);
      repeat (5) @(posedge mclk);
      #2;
      check({7'h00, power_fault_flag}, 8'h01);
      u_acr_host.write_reg(8'h2C, 8'h00);
      wait_fault(5, 1'b0);
      // Detector two on the PLL clock, other sources keep toggling
      u_acr_host.write_reg(8'h32, 8'h00);
      u_acr_host.write_reg(8'h2C, 8'h09);
      idle(200, 5'b01100);
      pulse(5'b10000);
      // Past the enable-based deadline, so only a restart keeps it quiet
      idle(100, 5'b01100);
      check({7'h00, power_fault_flag}, 8'h00);
      wait_fault(20500, 1'b1);
      check({6'h00, cmute, shdn}, 8'h01);
      pulse(5'b10000);
      wait_fault(10, 1'b0);
      print_verdict();
   end
endmodule : acr_regs_test
`default_nettype wire
